// ==== rtl/mbh_defines.svh ====
// Constants for the parallel host port: both ends share these.
// Assumes one 125 MHz system clock on both ends.
`ifndef MBH_DEFINES_SVH
`define MBH_DEFINES_SVH
`define MBH_DW 8
`define MBH_AW 7
`define MBH_NREG 128
`define MBH_REG_RST 8'h00
`define MBH_ADDR_RST 8'h00
// Synchroniser reset: pins at idle level, so no false edge after reset
`define MBH_PIN_IDLE 23'h7f80e0
// Host timing: count loaded for each phase; the strobe phase loads twice this
`define MBH_PHASE_CYC 4'h3
`define MBH_CNT_ZERO 4'h0
`endif

// ==== rtl/mbh_pkg.sv ====
// Types shared by both ends of the host port.
// Assumes mbh_defines.svh on the include path.
package mbh_pkg;
  typedef enum logic [1:0]
  {
    MBH_STYLE_SPLIT = 2'h0,
    MBH_STYLE_DIR = 2'h1
  } mbh_style_t;
  typedef enum logic [2:0]
  {
    MBH_H_IDLE = 3'h0,
    MBH_H_ADDR = 3'h1,
    MBH_H_GAP = 3'h3,
    MBH_H_STRB = 3'h2,
    MBH_H_DONE = 3'h6
  } mbh_hstate_t;
endpackage : mbh_pkg

// ==== rtl/mbh_bus_if.sv ====
// Pin bundle between host and device; resolves shared and open-drain wires.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface mbh_bus_if;
  logic [7:0] host_ad_out;
  logic host_ad_oe;
  logic [7:0] dev_ad_out;
  logic dev_ad_oe;
  logic [7:0] shared_addr_data_line;
  logic [6:0] separate_addr_line;
  logic chip_sel_n;
  logic wr_n_rw;
  logic rd_n_data_strobe_n;
  logic addr_latch;
  logic irq_oe;
  logic irq_n;
  logic reset_in_high;
  // Pull-up on the data lines when nobody drives
  assign shared_addr_data_line = host_ad_oe ? host_ad_out :
                                 (dev_ad_oe ? dev_ad_out : 8'hff);
  assign irq_n = irq_oe ? 1'b0 : 1'b1;
  modport device
  (
    input shared_addr_data_line, separate_addr_line, chip_sel_n,
    input wr_n_rw, rd_n_data_strobe_n, addr_latch, reset_in_high,
    output dev_ad_out, dev_ad_oe, irq_oe
  );
  modport host
  (
    input shared_addr_data_line, irq_n,
    output host_ad_out, host_ad_oe, separate_addr_line, chip_sel_n,
    output wr_n_rw, rd_n_data_strobe_n, addr_latch, reset_in_high
  );
endinterface : mbh_bus_if
`default_nettype wire

// ==== rtl/mbh_device.sv ====
// Device end: register file of 128 bytes behind the parallel host port.
// Assumes bus pins are asynchronous; all are synchronised before use.
`include "mbh_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mbh_device
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Straps
  input wire mbh_pkg::mbh_style_t style,
  input wire logic muxed,
  // Pins
  mbh_bus_if.device bus,
  // User side
  input wire logic irq_pending,
  output logic [7:0] last_wr_addr,
  output logic [7:0] last_wr_data,
  output logic wr_pulse
);
  import mbh_pkg::*;
  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  logic [22:0] s1, s2;
  logic [22:0] pins;
  assign pins = {bus.shared_addr_data_line, bus.separate_addr_line,
                 bus.chip_sel_n, bus.wr_n_rw, bus.rd_n_data_strobe_n,
                 bus.addr_latch, bus.reset_in_high, irq_pending,
                 style == MBH_STYLE_DIR, muxed};
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1 <= `MBH_PIN_IDLE;
      s2 <= `MBH_PIN_IDLE;
    end
    else
    begin
      s1 <= pins;
      s2 <= s1;
    end
  end
  logic [7:0] ad;
  logic [6:0] sa;
  logic cs_n, wrrw, rdds, ale, rst_hi, pend, dirm, mx;
  assign {ad, sa, cs_n, wrrw, rdds, ale, rst_hi, pend, dirm, mx} = s2;
  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  logic [7:0] addr, next_addr;
  logic rdds_d, wr_d, next_rdds_d, next_wr_d;
  logic [7:0] regs [0:`MBH_NREG-1];
  logic [7:0] dout, next_dout;
  logic oe, next_oe, irq, next_irq;
  logic [7:0] next_lwa, next_lwd;
  logic next_wp, do_wr;
  logic [6:0] idx;
  logic [7:0] eff_addr;
  assign eff_addr = mx ? addr : {1'b0, sa};
  // Bit 0 folds into the top index bit: when muxed, even or odd alone reach all
  assign idx = {eff_addr[7] ^ eff_addr[0], eff_addr[6:1]};
  always_comb
  begin
    next_addr = addr;
    next_rdds_d = rdds;
    next_wr_d = wrrw;
    next_oe = 1'b0;
    next_dout = dout;
    do_wr = 1'b0;
    next_irq = pend;
    if (mx && ale)
      next_addr = ad;
    // No capture at the latch fall: data already replaces the address
    if (!cs_n && !(mx && ale))
    begin
      if (!dirm)
      begin
        next_oe = !rdds;
        do_wr = wr_d && !wrrw;
      end
      else
      begin
        // Write at the strobe rise: data stays stable until then
        next_oe = wrrw && !rdds;
        do_wr = !rdds_d && rdds && !wrrw;
      end
      next_dout = regs[idx];
    end
    next_lwa = do_wr ? eff_addr : last_wr_addr;
    next_lwd = do_wr ? ad : last_wr_data;
    next_wp = do_wr;
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr <= `MBH_ADDR_RST;
      rdds_d <= 1'b1;
      wr_d <= 1'b1;
      oe <= 1'b0;
      dout <= `MBH_REG_RST;
      irq <= 1'b0;
      last_wr_addr <= `MBH_ADDR_RST;
      last_wr_data <= `MBH_REG_RST;
      wr_pulse <= 1'b0;
      for (int i = 0; i < `MBH_NREG; i++)
        regs[i] <= `MBH_REG_RST;
    end
    else if (rst_hi)
    begin
      addr <= `MBH_ADDR_RST;
      oe <= 1'b0;
      irq <= 1'b0;
      wr_pulse <= 1'b0;
      for (int i = 0; i < `MBH_NREG; i++)
        regs[i] <= `MBH_REG_RST;
    end
    else
    begin
      addr <= next_addr;
      rdds_d <= next_rdds_d;
      wr_d <= next_wr_d;
      oe <= next_oe;
      dout <= next_dout;
      irq <= next_irq;
      last_wr_addr <= next_lwa;
      last_wr_data <= next_lwd;
      wr_pulse <= next_wp;
      if (do_wr)
        regs[idx] <= ad;
    end
  end
  assign bus.dev_ad_out = dout;
  assign bus.dev_ad_oe = oe;
  assign bus.irq_oe = irq;
endmodule : mbh_device
`default_nettype wire

// ==== rtl/mbh_host.sv ====
// Host end: runs one read or write per request over the port pins.
// Assumes the device end shares sys_clk.
`include "mbh_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mbh_host
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Configuration
  input wire mbh_pkg::mbh_style_t style,
  input wire logic muxed,
  input wire logic dev_reset,
  // Requests
  input wire logic req,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_data,
  output logic busy,
  output logic done,
  output logic [7:0] rd_data,
  output logic irq_seen,
  // Pins
  mbh_bus_if.host bus
);
  import mbh_pkg::*;
  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  mbh_hstate_t st, next_st;
  logic [3:0] cnt, next_cnt;
  logic wr, next_wr, next_busy, next_done, next_irq;
  logic [7:0] a, next_a, d, next_d, next_rd;
  logic irq1, irq2;
  logic [7:0] ad1, ad2;
  logic cs_n, next_cs_n, s1_n, next_s1_n, s2_n, next_s2_n;
  logic ale, next_ale, oe, next_oe, rsth;
  logic [7:0] ado, next_ado;
  logic dirm;
  assign dirm = style == MBH_STYLE_DIR;
  always_comb
  begin
    next_st = st;
    next_cnt = cnt == `MBH_CNT_ZERO ? cnt : cnt - 4'h1;
    next_wr = wr;
    next_a = a;
    next_d = d;
    next_rd = rd_data;
    next_busy = busy;
    next_done = 1'b0;
    next_cs_n = cs_n;
    next_s1_n = s1_n;
    next_s2_n = s2_n;
    next_ale = muxed ? 1'b0 : dirm;
    next_oe = oe;
    next_ado = ado;
    next_irq = irq2;
    unique case (st)
      MBH_H_IDLE:
        if (req)
        begin
          next_wr = req_write;
          next_a = req_addr;
          next_d = req_data;
          next_busy = 1'b1;
          next_cnt = `MBH_PHASE_CYC;
          next_st = MBH_H_ADDR;
          if (muxed)
          begin
            next_ale = 1'b1;
            next_oe = 1'b1;
            next_ado = req_addr;
          end
        end
      MBH_H_ADDR:
      begin
        if (muxed)
          next_ale = cnt != `MBH_CNT_ZERO;
        if (cnt == `MBH_CNT_ZERO)
        begin
          next_cs_n = 1'b0;
          next_oe = wr;
          next_ado = d;
          next_s1_n = dirm ? !wr : 1'b1;
          next_cnt = `MBH_PHASE_CYC;
          next_st = MBH_H_GAP;
        end
      end
      MBH_H_GAP:
        if (cnt == `MBH_CNT_ZERO)
        begin
          if (dirm)
            next_s2_n = 1'b0;
          else if (wr)
            next_s1_n = 1'b0;
          else
            next_s2_n = 1'b0;
          next_cnt = `MBH_PHASE_CYC + `MBH_PHASE_CYC;
          next_st = MBH_H_STRB;
        end
      MBH_H_STRB:
        if (cnt == `MBH_CNT_ZERO)
        begin
          next_rd = wr ? rd_data : ad2;
          next_s1_n = dirm ? s1_n : 1'b1;
          next_s2_n = 1'b1;
          next_cnt = `MBH_PHASE_CYC;
          next_st = MBH_H_DONE;
        end
      MBH_H_DONE:
        if (cnt == `MBH_CNT_ZERO)
        begin
          next_cs_n = 1'b1;
          next_oe = 1'b0;
          next_busy = 1'b0;
          next_done = 1'b1;
          next_st = MBH_H_IDLE;
        end
      default:
        next_st = MBH_H_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= MBH_H_IDLE;
      cnt <= `MBH_CNT_ZERO;
      wr <= 1'b0;
      a <= `MBH_ADDR_RST;
      d <= `MBH_REG_RST;
      rd_data <= `MBH_REG_RST;
      busy <= 1'b0;
      done <= 1'b0;
      irq_seen <= 1'b0;
      cs_n <= 1'b1;
      s1_n <= 1'b1;
      s2_n <= 1'b1;
      ale <= 1'b0;
      oe <= 1'b0;
      ado <= `MBH_REG_RST;
      rsth <= 1'b0;
      irq1 <= 1'b0;
      irq2 <= 1'b0;
      ad1 <= `MBH_REG_RST;
      ad2 <= `MBH_REG_RST;
    end
    else
    begin
      st <= next_st;
      cnt <= next_cnt;
      wr <= next_wr;
      a <= next_a;
      d <= next_d;
      rd_data <= next_rd;
      busy <= next_busy;
      done <= next_done;
      irq_seen <= next_irq;
      cs_n <= next_cs_n;
      s1_n <= next_s1_n;
      s2_n <= next_s2_n;
      ale <= next_ale;
      oe <= next_oe;
      ado <= next_ado;
      rsth <= dev_reset;
      irq1 <= !bus.irq_n;
      irq2 <= irq1;
      ad1 <= bus.shared_addr_data_line;
      ad2 <= ad1;
    end
  end
  assign bus.chip_sel_n = cs_n;
  assign bus.wr_n_rw = s1_n;
  assign bus.rd_n_data_strobe_n = s2_n;
  assign bus.addr_latch = ale;
  assign bus.host_ad_out = ado;
  assign bus.host_ad_oe = oe;
  assign bus.separate_addr_line = a[6:0];
  assign bus.reset_in_high = rsth;
endmodule : mbh_host
`default_nettype wire

// ==== verification/mbh_checker.sv ====
// Pin-level checks on the host port between host and device ends.
// Assumes one clock, async active-low nrst, signals of mbh_bus_if.
`timescale 1ns/1ps
`default_nettype none
module mbh_checker
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Pins
  input wire logic [7:0] host_ad_out,
  input wire logic host_ad_oe,
  input wire logic dev_ad_oe,
  input wire logic [7:0] shared_addr_data_line,
  input wire logic chip_sel_n,
  input wire logic rd_n_data_strobe_n,
  input wire logic addr_latch,
  input wire logic irq_oe,
  input wire logic irq_n,
  input wire logic reset_in_high
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Access frame
  // ----------------------------------------
  sequence s_frame_open;
    $fell(chip_sel_n);
  endsequence
  // A stuck select would hang every later access
  sequence s_frame_close;
    ##[1:30] $rose(chip_sel_n);
  endsequence
  chk_frame_bounded: assert property (s_frame_open |-> s_frame_close)
    else $error("select held too long");
  chk_strobe_in_frame: assert property (
    $fell(rd_n_data_strobe_n) |-> !chip_sel_n)
    else $error("strobe fell outside select");
  chk_strobe_ends_first: assert property (
    $rose(rd_n_data_strobe_n) |-> !chip_sel_n)
    else $error("strobe rose after select");
  chk_latch_idle_cs: assert property (
    $rose(addr_latch) |-> chip_sel_n)
    else $error("latch raised inside access");
  // ----------------------------------------
  // Shared lines and interrupt
  // ----------------------------------------
  chk_no_contend: assert property (!(host_ad_oe && dev_ad_oe))
    else $error("both ends drive data lines");
  chk_dev_read_only: assert property ($rose(dev_ad_oe) |-> !chip_sel_n)
    else $error("device drives without select");
  chk_wr_data_held: assert property (
    $past(host_ad_oe && !chip_sel_n) && host_ad_oe && !chip_sel_n
    |-> $stable(host_ad_out))
    else $error("write data moved in access");
  chk_reset_quiet: assert property (
    reset_in_high [*4] |-> !irq_oe && !dev_ad_oe)
    else $error("device active in reset");
  chk_irq_drive: assert property (irq_oe |-> !irq_n)
    else $error("interrupt line not pulled");
  chk_pull_up: assert property (
    !host_ad_oe && !dev_ad_oe |-> shared_addr_data_line == 8'hff)
    else $error("idle data lines not high");
endmodule : mbh_checker
`default_nettype wire

// ==== verification/micro_bus_host_port_tb.sv ====
// Self-checking bench: host end and device end joined by mbh_bus_if.
// Assumes rtl/mbh_pkg.sv and the include path for mbh_defines.svh.
`timescale 1ns/1ps
`default_nettype none
module micro_bus_host_port_tb;
  import mbh_pkg::*;
  logic sys_clk, nrst, muxed, dev_reset, req, req_write, irq_pending;
  logic busy, done, irq_seen, wr_pulse;
  logic [7:0] req_addr, req_data, rd_data, last_wr_addr, last_wr_data;
  logic [7:0] a, d, q;
  mbh_style_t style;
  int miscompares, n_tests, n_wr, w0;
  mbh_bus_if bus_if();
  mbh_host u_mbh_host(.sys_clk(sys_clk), .nrst(nrst), .style(style),
    .muxed(muxed), .dev_reset(dev_reset), .req(req), .req_write(req_write),
    .req_addr(req_addr), .req_data(req_data), .busy(busy), .done(done),
    .rd_data(rd_data), .irq_seen(irq_seen), .bus(bus_if));
  mbh_device u_mbh_device(.sys_clk(sys_clk), .nrst(nrst), .style(style),
    .muxed(muxed), .bus(bus_if), .irq_pending(irq_pending),
    .last_wr_addr(last_wr_addr), .last_wr_data(last_wr_data),
    .wr_pulse(wr_pulse));
  mbh_checker u_mbh_checker(.sys_clk(sys_clk), .nrst(nrst),
    .host_ad_out(bus_if.host_ad_out), .host_ad_oe(bus_if.host_ad_oe),
    .dev_ad_oe(bus_if.dev_ad_oe),
    .shared_addr_data_line(bus_if.shared_addr_data_line),
    .chip_sel_n(bus_if.chip_sel_n),
    .rd_n_data_strobe_n(bus_if.rd_n_data_strobe_n),
    .addr_latch(bus_if.addr_latch), .irq_oe(bus_if.irq_oe),
    .irq_n(bus_if.irq_n), .reset_in_high(bus_if.reset_in_high));
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    if (wr_pulse === 1'b1)
      n_wr <= n_wr + 1;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", name, e, g);
      miscompares++;
    end
  endtask : chk
  // One access; done is sampled at the falling edge, clear of its update
  task automatic access(input logic w, input logic [7:0] ad,
                        input logic [7:0] dt, output logic [7:0] rq);
    int n;
    n = 0;
    req <= 1'b1;
    req_write <= w;
    req_addr <= ad;
    req_data <= dt;
    @(posedge sys_clk);
    req <= 1'b0;
    @(negedge sys_clk);
    chk("busy", 8'h01, {7'h00, busy});
    while (done !== 1'b1 && n < 100)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 100)
      chk("done", 8'h01, 8'h00);
    rq = rd_data;
    @(posedge sys_clk);
  endtask : access
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    sys_clk = 0;
    nrst = 0;
    style = MBH_STYLE_SPLIT;
    muxed = 1;
    dev_reset = 0;
    req = 0;
    req_write = 0;
    req_addr = 8'h00;
    req_data = 8'h00;
    irq_pending = 0;
    miscompares = 0;
    n_tests = 0;
    n_wr = 0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1;
    repeat (2) @(posedge sys_clk);
    for (int m = 0; m < 4; m++)
    begin
      style <= m[0] ? MBH_STYLE_DIR : MBH_STYLE_SPLIT;
      muxed <= ~m[1];
      repeat (4) @(posedge sys_clk);
      // Top bit set: when muxed it pairs with bit 0 to pick the register
      a = 8'hff - 8'(2 * m);
      d = 8'ha5 ^ 8'(m);
      w0 = n_wr;
      access(1'b1, a, d, q);
      chk("wr_data", d, last_wr_data);
      chk("wr_addr", {1'b0, a[6:0]}, {1'b0, last_wr_addr[6:0]});
      access(1'b1, a - 8'h01, ~d, q);
      chk("wr_count", 8'h02, 8'(n_wr - w0));
      access(1'b0, {1'b0, a[6:0]}, 8'h00, q);
      chk("rd_first", muxed ? ~d : d, q);
      access(1'b0, a - 8'h01, 8'h00, q);
      chk("rd_second", ~d, q);
      access(1'b0, 8'h40, 8'h00, q);
      chk("rd_blank", 8'h00, q);
      chk("idle_lines", 8'hff, bus_if.shared_addr_data_line);
      chk("busy_idle", 8'h00, {7'h00, busy});
    end
    irq_pending <= 1;
    repeat (8) @(negedge sys_clk);
    chk("irq_on", 8'h01, {7'h00, irq_seen});
    @(posedge sys_clk);
    irq_pending <= 0;
    repeat (8) @(negedge sys_clk);
    chk("irq_off", 8'h00, {7'h00, irq_seen});
    @(posedge sys_clk);
    irq_pending <= 1;
    dev_reset <= 1;
    repeat (10) @(negedge sys_clk);
    chk("irq_in_reset", 8'h00, {7'h00, irq_seen});
    @(posedge sys_clk);
    dev_reset <= 0;
    irq_pending <= 0;
    repeat (6) @(posedge sys_clk);
    access(1'b0, 8'h7f, 8'h00, q);
    chk("rd_after_reset", 8'h00, q);
    give_verdict();
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end
endmodule : micro_bus_host_port_tb
`default_nettype wire
